// [fmpg_regs.vh]
/*
  Constants for the fault monitor and power-good block: timing counts
  in switching cycles and state codes.
  Assumes inclusion by fmpg_fault_monitor.v only.
*/
`ifndef FMPG_REGS_VH
`define FMPG_REGS_VH

// Timing counts, in switching cycles
`define FMPG_SS_DELAY_CYC 13'h0040
`define FMPG_HICCUP_CYC 13'h1000
`define FMPG_CNT_W 13

// Sequencer states
`define FMPG_ST_SHUT 3'h0
`define FMPG_ST_DELAY 3'h1
`define FMPG_ST_RAMP 3'h2
`define FMPG_ST_RUN 3'h3
`define FMPG_ST_HICCUP 3'h4
`define FMPG_ST_OPEN 3'h5

`endif

// [fmpg_fault_monitor.v]
/*
  Fault supervision and power-good logic of a multiphase buck controller.
  Analog comparators are outside; their results arrive asynchronously and
  are synchronised here. The clock is the switching-cycle clock, one edge
  per switching cycle, gated by a clock enable.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fmpg_regs.vh"

// Overview of operation
// RULE1 - Power ok low in shutdown, high after soft-start
// RULE2 - Any fault or disable pulls power ok low
// RULE3 - Power ok returns once inside both limits
// RULE4 - Undervoltage below 82 percent only drops power ok
// RULE5 - Undervoltage clears above 85 percent
// RULE6 - Soft-start trip: max of ref+150mV, 1.67V; code trips on either comparator, so at the lower of the two
// RULE7 - After soft-start only ref+150mV trip used
// RULE8 - Release 50mV or 100mV below, record source
// RULE9 - Overvoltage forces low gates high until release; code clamps in ramp and run only, not in the soft-start delay
// RULE10 - Clamp repeats; recovery needs no restart
// RULE11 - Open sense comparator shuts controller down
// RULE12 - Open sense cleared restarts from soft-start start
// RULE13 - Droop above setpoint starts overcurrent shutdown
// RULE14 - Overcurrent: all gates off 4096 cycles
// RULE15 - Retry soft-start after wait if enabled
// RULE16 - Trip-retry repeats without limit
// RULE17 - Shutdown keeps pulse outputs high-impedance
// RULE18 - Soft-start begins with 64 cycle delay
// RULE19 - Power ok low through every soft-start
// RULE20 - Shutdown faults override clamp; disable aborts hiccup
module fmpg_fault_monitor (
  // Clock, reset, enable
  input wire clk_sys_in,
  input wire rstn_in,
  input wire ce_in,
  // Enable conditions, asynchronous comparators
  input wire enable_threshold_in,
  input wire por_ok_in,
  // Undervoltage comparators, asynchronous
  input wire uv_below_82_in,
  input wire uv_above_85_in,
  // Overvoltage comparators, asynchronous
  input wire ov_ref_trip_in,
  input wire ov_ref_release_in,
  input wire ov_fixed_trip_in,
  input wire ov_fixed_release_in,
  // Open sense and overcurrent comparators, asynchronous
  input wire open_sense_in,
  input wire overcurrent_in,
  // Soft-start sequencer, same clock
  input wire ss_done_in,
  // Sequencer control
  output reg ss_delay_out,
  output reg ss_ramp_out,
  output reg ss_restart_out,
  // Gate control
  output reg pwm_hiz_out,
  output reg gates_off_out,
  output reg low_side_gate_force_out,
  // Power ok open-drain pin
  output reg power_ok_out,
  output reg power_ok_oe_out
);

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [`FMPG_CNT_W-1:0] cnt_r;
  reg [`FMPG_CNT_W-1:0] cnt_nxt;
  reg uv_r;
  reg ov_r;
  reg ov_fixed_src_r;
  reg ov_r_nxt;
  reg ov_fixed_src_nxt;
  reg uv_nxt;
  wire en_thr_s;
  wire por_s;
  wire en_ok;
  wire uv_trip;
  wire uv_clear;
  wire ovr_trip;
  wire ovr_rel;
  wire ovf_trip;
  wire ovf_rel;
  wire open_s;
  wire oc;
  wire in_ss;
  wire good_nxt;

  // Each comparator synchronised alone; enable terms combined only after
  fmpg_sync2 #(.W(1)) sync_en_u (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .ce_in(ce_in),
    .d_in(enable_threshold_in),
    .q_out(en_thr_s)
  );
  fmpg_sync2 #(.W(1)) sync_por_u (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .ce_in(ce_in),
    .d_in(por_ok_in),
    .q_out(por_s)
  );
  fmpg_sync2 #(.W(1)) sync_uvt_u (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .ce_in(ce_in),
    .d_in(uv_below_82_in),
    .q_out(uv_trip)
  );
  fmpg_sync2 #(.W(1)) sync_uvc_u (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .ce_in(ce_in),
    .d_in(uv_above_85_in),
    .q_out(uv_clear)
  );
  fmpg_sync2 #(.W(1)) sync_ovrt_u (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .ce_in(ce_in),
    .d_in(ov_ref_trip_in),
    .q_out(ovr_trip)
  );
  fmpg_sync2 #(.W(1)) sync_ovrr_u (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .ce_in(ce_in),
    .d_in(ov_ref_release_in),
    .q_out(ovr_rel)
  );
  fmpg_sync2 #(.W(1)) sync_ovft_u (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .ce_in(ce_in),
    .d_in(ov_fixed_trip_in),
    .q_out(ovf_trip)
  );
  fmpg_sync2 #(.W(1)) sync_ovfr_u (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .ce_in(ce_in),
    .d_in(ov_fixed_release_in),
    .q_out(ovf_rel)
  );
  fmpg_sync2 #(.W(1)) sync_open_u (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .ce_in(ce_in),
    .d_in(open_sense_in),
    .q_out(open_s)
  );
  fmpg_sync2 #(.W(1)) sync_oc_u (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .ce_in(ce_in),
    .d_in(overcurrent_in),
    .q_out(oc)
  );

  assign en_ok = en_thr_s & por_s;

  assign in_ss = (state_r == `FMPG_ST_DELAY) || (state_r == `FMPG_ST_RAMP);

  // Sequencer and hiccup timer
  always @*
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    if (!en_ok)
    begin
      state_nxt = `FMPG_ST_SHUT; // [RULE20]
      cnt_nxt = {`FMPG_CNT_W{1'b0}};
    end
    else
    begin
      case (state_r)
        `FMPG_ST_SHUT:
        begin
          state_nxt = `FMPG_ST_DELAY;
          cnt_nxt = {`FMPG_CNT_W{1'b0}};
        end
        `FMPG_ST_DELAY:
        begin
          cnt_nxt = cnt_r + 1'b1;
          if (cnt_r == `FMPG_SS_DELAY_CYC - 1'b1)
          begin
            state_nxt = `FMPG_ST_RAMP; // [RULE18]
            cnt_nxt = {`FMPG_CNT_W{1'b0}};
          end
        end
        `FMPG_ST_RAMP:
          if (ss_done_in)
            state_nxt = `FMPG_ST_RUN;
        `FMPG_ST_RUN:
          state_nxt = `FMPG_ST_RUN;
        `FMPG_ST_HICCUP:
        begin
          cnt_nxt = cnt_r + 1'b1;
          if (cnt_r == `FMPG_HICCUP_CYC - 1'b1)
          begin
            state_nxt = `FMPG_ST_DELAY; // [RULE15] [RULE16]
            cnt_nxt = {`FMPG_CNT_W{1'b0}};
          end
        end
        `FMPG_ST_OPEN:
          if (!open_s)
          begin
            state_nxt = `FMPG_ST_DELAY; // [RULE12]
            cnt_nxt = {`FMPG_CNT_W{1'b0}};
          end
        default:
          state_nxt = `FMPG_ST_SHUT;
      endcase
      // Shutdown faults checked in every active state
      if (state_r != `FMPG_ST_SHUT && state_r != `FMPG_ST_HICCUP &&
          state_r != `FMPG_ST_OPEN)
      begin
        if (open_s)
        begin
          state_nxt = `FMPG_ST_OPEN; // [RULE11]
          cnt_nxt = {`FMPG_CNT_W{1'b0}};
        end
        else if (oc)
        begin
          state_nxt = `FMPG_ST_HICCUP; // [RULE13] [RULE14]
          cnt_nxt = {`FMPG_CNT_W{1'b0}};
        end
      end
    end
  end

  // Fault flags; hysteresis through separate trip and release comparators
  always @*
  begin
    uv_nxt = uv_r;
    ov_r_nxt = ov_r;
    ov_fixed_src_nxt = ov_fixed_src_r;
    if (uv_trip)
      uv_nxt = 1'b1; // [RULE4]
    else if (uv_clear)
      uv_nxt = 1'b0; // [RULE5]
    if (!ov_r)
    begin
      if (ovr_trip)
      begin
        ov_r_nxt = 1'b1; // [RULE6] [RULE7]
        ov_fixed_src_nxt = 1'b0;
      end
      else if (ovf_trip && in_ss)
      begin
        ov_r_nxt = 1'b1; // [RULE6]
        ov_fixed_src_nxt = 1'b1;
      end
    end
    else if (ov_fixed_src_r ? ovf_rel : ovr_rel)
      ov_r_nxt = 1'b0; // [RULE8] [RULE10]
    if (!en_ok)
    begin
      ov_r_nxt = 1'b0;
      uv_nxt = 1'b0;
    end
  end

  // Power ok only when running with no fault; low through soft-start
  assign good_nxt = (state_nxt == `FMPG_ST_RUN) && !uv_nxt && !ov_r_nxt && !oc &&
                    !open_s; // [RULE1] [RULE2] [RULE3] [RULE19]

  always @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_r <= `FMPG_ST_SHUT;
      cnt_r <= {`FMPG_CNT_W{1'b0}};
      uv_r <= 1'b0;
      ov_r <= 1'b0;
      ov_fixed_src_r <= 1'b0;
      ss_delay_out <= 1'b0;
      ss_ramp_out <= 1'b0;
      ss_restart_out <= 1'b0;
      pwm_hiz_out <= 1'b1;
      gates_off_out <= 1'b1;
      low_side_gate_force_out <= 1'b0;
      power_ok_out <= 1'b0;
      power_ok_oe_out <= 1'b1;
    end
    else if (ce_in)
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      uv_r <= uv_nxt;
      ov_r <= ov_r_nxt;
      ov_fixed_src_r <= ov_fixed_src_nxt;
      ss_delay_out <= (state_nxt == `FMPG_ST_DELAY);
      ss_ramp_out <= (state_nxt == `FMPG_ST_RAMP);
      ss_restart_out <= (state_nxt == `FMPG_ST_DELAY) && (state_r != `FMPG_ST_DELAY);
      // Hi-Z in shutdown and soft-start delay keeps the drivers off
      pwm_hiz_out <= (state_nxt == `FMPG_ST_SHUT) ||
                     (state_nxt == `FMPG_ST_DELAY); // [RULE17]
      gates_off_out <= (state_nxt == `FMPG_ST_SHUT) || (state_nxt == `FMPG_ST_HICCUP) ||
                       (state_nxt == `FMPG_ST_OPEN); // [RULE14]
      // Clamp only in switching states, so shutdown faults win
      low_side_gate_force_out <= ov_r_nxt && ((state_nxt == `FMPG_ST_RAMP) ||
                                 (state_nxt == `FMPG_ST_RUN)); // [RULE9] [RULE20]
      // Open drain: pin never driven high, enable low releases it
      power_ok_out <= 1'b0;
      power_ok_oe_out <= !good_nxt; // [RULE2]
    end
  end

endmodule // fmpg_fault_monitor

module fmpg_sync2 #(
  parameter W = 1
) (
  // Clock, reset, enable
  input wire clk_sys_in,
  input wire rstn_in,
  input wire ce_in,
  // Asynchronous level in, synchronised level out
  input wire [W-1:0] d_in,
  output reg [W-1:0] q_out
);

  // First stage feeds only the second
  reg [W-1:0] meta_r;

  always @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      meta_r <= {W{1'b0}};
      q_out <= {W{1'b0}};
    end
    else if (ce_in)
    begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end

endmodule // fmpg_sync2
`default_nettype wire

// [fmpg_monitor.sv]
/* Checker on the fault monitor outputs.
   Assumes ce_in stays high, so every edge counts. */
`timescale 1ns/1ps
`default_nettype none
module fmpg_monitor (
  // Clock, reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // Watched outputs
  input wire logic ss_delay_out,
  input wire logic ss_ramp_out,
  input wire logic ss_restart_out,
  input wire logic pwm_hiz_out,
  input wire logic gates_off_out,
  input wire logic low_side_gate_force_out,
  input wire logic power_ok_out,
  input wire logic power_ok_oe_out
);
  logic [7:0] dly_r;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  // Counts delay cycles; too long for a repetition
  always @(posedge clk_sys_in or negedge rstn_in)
    if (!rstn_in)
      dly_r <= 8'h00;
    else
      dly_r <= ss_delay_out ? dly_r + 8'h01 : 8'h00;
  sequence s_ramp_go;
    $fell(ss_delay_out) ##0 ss_ramp_out;
  endsequence
  a_delay_len: assert property (s_ramp_go |-> dly_r == 8'h40)
    else $error("bad delay");
  a_pin_data: assert property (power_ok_out == 1'b0)
    else $error("bad pin data");
  a_restart_pulse: assert property (ss_restart_out |-> ss_delay_out ##1 !ss_restart_out)
    else $error("bad restart");
  a_delay_hiz: assert property (ss_delay_out |-> pwm_hiz_out && power_ok_oe_out)
    else $error("bad delay hiz");
  a_ramp_pok: assert property (ss_ramp_out |-> power_ok_oe_out)
    else $error("bad ramp pok");
  a_clamp_pok: assert property (low_side_gate_force_out |-> power_ok_oe_out && !gates_off_out)
    else $error("bad clamp");
  a_off_pok: assert property (gates_off_out |-> power_ok_oe_out && !low_side_gate_force_out)
    else $error("bad off");
  a_ok_running: assert property (!power_ok_oe_out |-> !(pwm_hiz_out || gates_off_out))
    else $error("bad pok");
endmodule // fmpg_monitor
bind fmpg_fault_monitor fmpg_monitor chk_u (.clk_sys_in, .rstn_in, .ss_delay_out,
  .ss_ramp_out, .ss_restart_out, .pwm_hiz_out, .gates_off_out, .low_side_gate_force_out,
  .power_ok_out, .power_ok_oe_out);
`default_nettype wire

// [fmpg_sysmon.sv]
/* System monitor on the power ok line.
   Assumes a pull-up on the line. */
`timescale 1ns/1ps
`default_nettype none
module fmpg_sysmon (
  // Open-drain driver
  input wire logic power_ok_out,
  input wire logic power_ok_oe_out,
  // Line level
  output logic pok_level_out
);
  // Released line reads the pull-up, never a stale value
  assign pok_level_out = power_ok_oe_out ? power_ok_out : 1'b1;
endmodule // fmpg_sysmon
`default_nettype wire

// [fault_monitor_power_good_tb.sv]
/* Bench for the fault monitor with a power ok monitor.
   Assumes ce_in high; comparator inputs act 3 edges after a change, ss_done_in after 1. */
`timescale 1ns/1ps
`default_nettype none
module fault_monitor_power_good_tb;
  logic clk_sys_in, rstn_in, ce_in, en, por, ub, ua, vr, vrr, vf, vfr, op, oc, sd;
  wire dly, rmp, rs, hiz, off, frc, pd, poe, pok;
  int n_mismatch = 0, checked = 0, i, n;
  fmpg_fault_monitor dut_u (.clk_sys_in, .rstn_in, .ce_in, .enable_threshold_in(en),
    .por_ok_in(por), .uv_below_82_in(ub), .uv_above_85_in(ua), .ov_ref_trip_in(vr),
    .ov_ref_release_in(vrr), .ov_fixed_trip_in(vf), .ov_fixed_release_in(vfr),
    .open_sense_in(op), .overcurrent_in(oc), .ss_done_in(sd), .ss_delay_out(dly),
    .ss_ramp_out(rmp), .ss_restart_out(rs), .pwm_hiz_out(hiz), .gates_off_out(off),
    .low_side_gate_force_out(frc), .power_ok_out(pd), .power_ok_oe_out(poe));
  fmpg_sysmon mon_u (.power_ok_out(pd), .power_ok_oe_out(poe), .pok_level_out(pok));
  initial
  begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  task st(input int k);
    repeat (k) @(posedge clk_sys_in);
    #1;
  endtask
  task chk(input logic [12:0] g, e);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task conclude;
    if (n_mismatch == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task wr;
    for (i = 0; i < 20 && rs !== 1'b1; i++)
      st(1);
    chk(rs, 1'b1);
  endtask
  // Entered just after a restart pulse
  task start;
    st(63);
    chk({dly, hiz}, 2'h3);
    st(1);
    chk({rmp, hiz, pok}, 3'h4);
    sd <= 1'b1;
    st(1);
    chk({rmp, pok}, 2'h1);
    sd <= 1'b0;
  endtask
  initial
  begin
    n = $urandom(55685);
    {rstn_in, en, por, ub, vr, vf, op, oc, sd} = 9'h000;
    {ce_in, ua, vrr, vfr} = 4'hf;
    st(10);
    chk({hiz, off, pok}, 3'h6);
    {rstn_in, en, por} <= 3'h7;
    wr();
    start();
    st(1 + $urandom % 8);
    {ub, ua} <= 2'h2;
    st(4);
    chk({pok, off, frc, hiz}, 4'h0);
    ub <= 1'b0;
    st(4);
    chk(pok, 1'b0);
    ua <= 1'b1;
    st(4);
    chk(pok, 1'b1);
    // Clamp must repeat each time
    for (i = 0; i < 2; i++)
    begin
      st(1 + $urandom % 8);
      {vr, vrr} <= 2'h2;
      st(4);
      chk({frc, pok}, 2'h2);
      vr <= 1'b0;
      st(4);
      chk(frc, 1'b1);
      vrr <= 1'b1;
      st(4);
      chk({frc, pok}, 2'h1);
    end
    {vf, vfr} <= 2'h2;
    st(4);
    chk({frc, pok}, 2'h1);
    {vf, vfr, oc} <= 3'h3;
    st(4);
    chk({off, pok}, 2'h2);
    oc <= 1'b0;
    for (n = 0; n < 5000 && rs !== 1'b1; n++)
      st(1);
    chk(n[12:0], 13'h0fff);
    start();
    st(1 + $urandom % 8);
    op <= 1'b1;
    st(4);
    chk({off, pok}, 2'h2);
    st(1 + $urandom % 8);
    op <= 1'b0;
    wr();
    start();
    en <= 1'b0;
    st(4);
    chk({hiz, pok}, 2'h2);
    en <= 1'b1;
    wr();
    st(64);
    {vf, vfr} <= 2'h2;
    st(4);
    chk({rmp, frc, pok}, 3'h6);
    vf <= 1'b0;
    st(4);
    chk(frc, 1'b1);
    vfr <= 1'b1;
    st(4);
    chk({frc, pok}, 2'h0);
    sd <= 1'b1;
    st(1);
    chk({rmp, pok}, 2'h1);
    sd <= 1'b0;
    oc <= 1'b1;
    st(4);
    chk({off, pok}, 2'h2);
    for (n = 0; n < 5000 && rs !== 1'b1; n++)
      st(1);
    chk(rs, 1'b1);
    st(1);
    chk({off, dly}, 2'h2);
    en <= 1'b0;
    st(4);
    chk({hiz, off, pok}, 3'h6);
    conclude();
  end
  initial
  begin
    #200000;
    n_mismatch++;
    conclude();
  end
endmodule // fault_monitor_power_good_tb
`default_nettype wire
